/* logic/cal_lock.sv */
// calibration security lock, counter and message keeper
`timescale 1ns/10ps
`default_nettype none
`include "cal_lock_cfg.svh"
module cal_lock #(
   parameter int unsigned HOLD_CYC = `CAL_HOLD_S * `CLK_HZ,
   parameter int unsigned SHOW_CYC = `SHOW_S * `CLK_HZ
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cal_key_i,
   input wire logic fp_secure_i,
   input wire logic [5:0][3:0] fp_digits_i,
   input wire logic jumper_i,
   input wire logic cal_point_i,
   input wire logic req_valid_i,
   input wire cal_lock_pkg::req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output cal_lock_pkg::rsp_t rsp_o,
   input wire logic nv_blank_i,
   input wire cal_lock_pkg::nv_image_t nv_image_i,
   output logic nv_write_o,
   output cal_lock_pkg::nv_image_t nv_image_o,
   output logic secured_o,
   output logic cal_mode_o,
   output cal_lock_pkg::disp_t disp_o
);
   import cal_lock_pkg::*;

   typedef enum logic [3:0] {
      ST_LOAD, ST_BOOT, ST_RUN, ST_SHOW, ST_CAL, ST_ENTRY, ST_UNSEC_SHOW, ST_INVALID, ST_SEC_SHOW
   } state_t;

   state_t state_reg;
   state_t state_next;
   disp_t disp_reg;
   disp_t disp_next;
   logic [27:0] timer_reg;
   logic [27:0] timer_next;
   logic secured_reg;
   code_t code_reg;
   logic [14:0] count_reg;
   logic cal_mode_reg;
   logic nv_write_reg;
   logic rsp_valid_reg;
   logic rsp_ok_reg;
   logic rsp_rd_reg;
   logic [14:0] rsp_count_reg;
   char_t msg_rd_w;

   // timers
   logic hold_done_w;
   logic show_done_w;
   assign hold_done_w = timer_reg == 28'(HOLD_CYC - 1);
   assign show_done_w = timer_reg == 28'(SHOW_CYC - 1);

   // front-panel decode
   char_t [5:0] fp_ascii_w;
   code_t fp_new_code_w;
   logic fp_eval_w;
   logic fp_match_w;
   logic fp_unlock_w;
   logic fp_bad_w;
   logic fp_lock_w;
   logic persist_w;
   genvar k;
   generate
      for (k = 0; k < `FP_DIGITS; k++) begin : g_fp
         assign fp_ascii_w[k] = `ASCII_ZERO + {4'h0, fp_digits_i[k]};
      end
   endgenerate
   assign fp_eval_w = state_reg == ST_ENTRY && fp_secure_i;
   assign fp_match_w = code_reg.len == `FP_LEN && fp_ascii_w == code_reg.ch[7:2];
   // prefix kept from the stored code, digits from the panel
   assign fp_new_code_w = '{len: `FP_LEN, ch: {32'h0000_0000, fp_ascii_w, code_reg.ch[1:0]}};
   assign fp_unlock_w = fp_eval_w && secured_reg && (fp_match_w || jumper_i);
   assign fp_bad_w = fp_eval_w && secured_reg && !fp_match_w && !jumper_i;
   assign fp_lock_w = fp_eval_w && !secured_reg;
   assign persist_w = state_reg == ST_UNSEC_SHOW && show_done_w;

   // remote decode
   logic req_fire_w;
   logic given_valid_w;
   logic match_w;
   logic is_state_w;
   logic set_on_ok_w;
   logic set_off_ok_w;
   logic is_chg_w;
   logic chg_ok_w;
   logic cnt_q_w;
   logic is_msg_wr_w;
   logic msg_wr_ok_w;
   logic msg_rd_w_en;
   logic count_inc_w;

   code_check u_check (
      .given_i(req_i.code),
      .stored_i(code_reg),
      .valid_o(given_valid_w),
      .match_o(match_w)
   );

   // panel evaluation and persist cycles own the stored state
   assign req_ready_o = !(fp_eval_w || persist_w || state_reg == ST_LOAD);
   assign req_fire_w = req_valid_i && req_ready_o;
   assign is_state_w = req_fire_w && req_i.op == set_security_state_cmd;
   assign set_on_ok_w = is_state_w && req_i.on && given_valid_w && match_w;
   assign set_off_ok_w = is_state_w && !req_i.on && (match_w || jumper_i);
   assign is_chg_w = req_fire_w && req_i.op == change_security_code_cmd;
   assign chg_ok_w = is_chg_w && (!secured_reg || jumper_i) && given_valid_w;
   assign cnt_q_w = req_fire_w && req_i.op == read_calibration_counter_query;
   assign is_msg_wr_w = req_fire_w && req_i.op == store_calibration_message_cmd;
   assign msg_wr_ok_w = is_msg_wr_w && req_i.msg_addr < `MSG_LEN;
   assign msg_rd_w_en = req_fire_w && req_i.op == read_calibration_message_query;
   assign count_inc_w = cal_point_i && cal_mode_reg && !secured_reg;

   msg_store u_msg (
      .clk_i(clk_i),
      .wr_i(msg_wr_ok_w),
      .addr_i(req_i.msg_addr),
      .data_i(req_i.msg_char),
      .rd_data_o(msg_rd_w)
   );

   // front-panel and power-up sequence
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_LOAD: state_next = cal_key_i ? ST_BOOT : ST_RUN;
         ST_BOOT: begin
            if (!cal_key_i) begin
               state_next = ST_RUN;
            end else if (hold_done_w) begin
               state_next = ST_SHOW;
            end
         end
         ST_RUN: state_next = ST_RUN;
         ST_SHOW: state_next = show_done_w ? ST_CAL : ST_SHOW;
         ST_CAL: state_next = fp_secure_i ? ST_ENTRY : ST_CAL;
         ST_ENTRY: begin
            if (fp_unlock_w) begin
               state_next = ST_UNSEC_SHOW;
            end else if (fp_bad_w) begin
               state_next = ST_INVALID;
            end else if (fp_lock_w) begin
               state_next = ST_SEC_SHOW;
            end
         end
         ST_UNSEC_SHOW: state_next = show_done_w ? ST_CAL : ST_UNSEC_SHOW;
         ST_INVALID: state_next = show_done_w ? ST_ENTRY : ST_INVALID;
         ST_SEC_SHOW: state_next = show_done_w ? ST_CAL : ST_SEC_SHOW;
         default: state_next = ST_LOAD;
      endcase
      case (state_next)
         ST_SHOW: disp_next = secured_reg ? DISP_SECURED : DISP_UNSECURED;
         ST_CAL: disp_next = DISP_CAL_MODE;
         ST_ENTRY: disp_next = DISP_CODE;
         ST_UNSEC_SHOW: disp_next = DISP_UNSECURED;
         ST_INVALID: disp_next = DISP_INVALID;
         ST_SEC_SHOW: disp_next = DISP_SECURED;
         default: disp_next = DISP_BLANK;
      endcase
      timer_next = (state_next != state_reg) ? 28'h0000000 : timer_reg + 28'h0000001;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_LOAD;
         disp_reg <= DISP_BLANK;
         timer_reg <= 28'h0000000;
         cal_mode_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         disp_reg <= disp_next;
         timer_reg <= timer_next;
         cal_mode_reg <= cal_mode_reg || state_next == ST_SHOW;
      end
   end

   // security state and code; panel entry and remote requests never coincide
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         secured_reg <= 1'b1;
         code_reg <= '{len: `FACTORY_LEN, ch: `FACTORY_CODE};
      end else if (state_reg == ST_LOAD) begin
         if (!nv_blank_i) begin
            secured_reg <= nv_image_i.secured;
            code_reg <= nv_image_i.code;
         end
      end else begin
         if (set_on_ok_w || fp_lock_w) begin
            secured_reg <= 1'b1;
         end else if (set_off_ok_w || persist_w) begin
            secured_reg <= 1'b0;
         end
         if (chg_ok_w) begin
            code_reg <= req_i.code;
         end else if (fp_lock_w || (fp_unlock_w && jumper_i)) begin
            code_reg <= fp_new_code_w;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_reg <= 15'h0000;
      end else if (state_reg == ST_LOAD) begin
         count_reg <= nv_blank_i ? 15'h0000 : nv_image_i.count;
      end else if (count_inc_w) begin
         count_reg <= (count_reg == `CNT_MAX) ? 15'h0000 : count_reg + 15'h0001;
      end
   end

   // every change of security state, code or counter is written through to storage; message writes are not
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nv_write_reg <= 1'b0;
      end else begin
         nv_write_reg <= set_on_ok_w || set_off_ok_w || chg_ok_w || fp_lock_w
            || persist_w || (fp_unlock_w && jumper_i) || count_inc_w;
      end
   end

   // remote answers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsp_valid_reg <= 1'b0;
         rsp_ok_reg <= 1'b0;
         rsp_rd_reg <= 1'b0;
         rsp_count_reg <= 15'h0000;
      end else begin
         rsp_valid_reg <= req_fire_w;
         rsp_ok_reg <= set_on_ok_w || set_off_ok_w || chg_ok_w || cnt_q_w || msg_wr_ok_w || msg_rd_w_en;
         rsp_rd_reg <= msg_rd_w_en;
         rsp_count_reg <= cnt_q_w ? count_reg : 15'h0000;
      end
   end

   assign rsp_valid_o = rsp_valid_reg;
   assign rsp_o = '{ok: rsp_ok_reg, secured: secured_reg, count: rsp_count_reg,
      msg_char: rsp_rd_reg ? msg_rd_w : 8'h00};
   assign nv_write_o = nv_write_reg;
   assign nv_image_o = '{secured: secured_reg, code: code_reg, count: count_reg};
   assign secured_o = secured_reg;
   assign cal_mode_o = cal_mode_reg;
   assign disp_o = disp_reg;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_fp_good;
      state_reg == ST_ENTRY && fp_secure_i && secured_reg && fp_match_w;
   endsequence
   sequence s_fp_bad;
      state_reg == ST_ENTRY && fp_secure_i && secured_reg && !fp_match_w && !jumper_i;
   endsequence

   a_fp_unlock_show : assert property (s_fp_good |=> disp_o == DISP_UNSECURED && secured_reg)
      else $error("correct panel code did not show unsecured");
   a_persist_after : assert property (persist_w |=> !secured_reg && nv_write_o && state_reg == ST_CAL)
      else $error("unsecured state not persisted");
   a_fp_invalid : assert property (s_fp_bad |=> disp_o == DISP_INVALID && secured_reg ##0 $stable(code_reg))
      else $error("wrong panel code handled badly");
   a_remote_on : assert property (set_on_ok_w |=> secured_reg && nv_write_o && rsp_o.ok)
      else $error("remote secure not applied");
   a_unsec_reject : assert property (is_state_w && !req_i.on && !match_w && !jumper_i
      |=> $stable(secured_reg) && rsp_valid_o && !rsp_o.ok)
      else $error("unsecure accepted with wrong code");
   a_code_locked : assert property (is_chg_w && secured_reg && !jumper_i |=> $stable(code_reg))
      else $error("code changed while secured");
   a_bad_format : assert property (is_state_w && req_i.on && !given_valid_w |=> !rsp_o.ok)
      else $error("malformed code accepted");
   a_cnt_wrap : assert property (count_inc_w && count_reg == `CNT_MAX |=> count_reg == 15'h0000)
      else $error("counter did not wrap");
   a_cal_sticky : assert property (cal_mode_o |=> cal_mode_o)
      else $error("calibration mode left without power cycle");
   a_msg_range : assert property (is_msg_wr_w && req_i.msg_addr >= `MSG_LEN |=> !rsp_o.ok)
      else $error("message write beyond length accepted");
   a_show_state : assert property (state_reg == ST_BOOT && cal_key_i && hold_done_w
      |=> cal_mode_o && disp_o == ($past(secured_reg) ? DISP_SECURED : DISP_UNSECURED))
      else $error("calibration entry not shown");
endmodule : cal_lock
`default_nettype wire

/* logic/cal_lock_cfg.svh */
// timing, sizing and reset constants of the calibration lock
`ifndef CAL_LOCK_CFG_SVH
`define CAL_LOCK_CFG_SVH
`define CLK_HZ 50000000
`define CAL_HOLD_S 5
`define SHOW_S 1
`define CODE_MAX 4'hC
`define FP_LEN 4'h8
`define FP_DIGITS 6
`define CNT_MAX 15'h7FFF
`define MSG_LEN 6'h28
`define ASCII_ZERO 8'h30
// arbitrary factory code "ZQ000000"
`define FACTORY_CODE 96'h0000_0000_3030_3030_3030_515A
`define FACTORY_LEN 4'h8
`endif

/* logic/cal_lock_pkg.sv */
// types shared by the calibration lock files
`default_nettype none
package cal_lock_pkg;
   typedef logic [7:0] char_t;
   typedef struct packed {
      logic [3:0] len;
      char_t [11:0] ch;
   } code_t;
   typedef enum logic [2:0] {
      set_security_state_cmd,
      change_security_code_cmd,
      read_calibration_counter_query,
      store_calibration_message_cmd,
      read_calibration_message_query
   } op_t;
   typedef struct packed {
      op_t op;
      logic on;
      code_t code;
      logic [5:0] msg_addr;
      char_t msg_char;
   } req_t;
   typedef struct packed {
      logic ok;
      logic secured;
      logic [14:0] count;
      char_t msg_char;
   } rsp_t;
   typedef struct packed {
      logic secured;
      code_t code;
      logic [14:0] count;
   } nv_image_t;
   typedef enum logic [2:0] {
      DISP_BLANK, DISP_SECURED, DISP_UNSECURED, DISP_CAL_MODE, DISP_CODE, DISP_INVALID
   } disp_t;
   function automatic logic is_letter(input char_t c);
      return (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
   endfunction : is_letter
endpackage : cal_lock_pkg
`default_nettype wire

/* logic/code_check.sv */
// format check and full-length compare of a supplied code
`timescale 1ns/10ps
`default_nettype none
`include "cal_lock_cfg.svh"
module code_check (
   input wire cal_lock_pkg::code_t given_i,
   input wire cal_lock_pkg::code_t stored_i,
   output logic valid_o,
   output logic match_o
);
   import cal_lock_pkg::*;
   logic [11:0] used_w;
   logic [11:0] alnum_w;
   logic [11:0] same_w;
   genvar i;
   generate
      for (i = 0; i < `CODE_MAX; i++) begin : g_ch
         assign used_w[i] = 4'(i) < given_i.len;
         assign alnum_w[i] = !used_w[i] || is_letter(given_i.ch[i])
            || (given_i.ch[i] >= 8'h30 && given_i.ch[i] <= 8'h39);
         assign same_w[i] = !used_w[i] || given_i.ch[i] == stored_i.ch[i];
      end
   endgenerate
   // one to twelve characters, letter first
   assign valid_o = given_i.len != 4'h0 && given_i.len <= `CODE_MAX
      && is_letter(given_i.ch[0]) && &alnum_w;
   assign match_o = given_i.len == stored_i.len && &same_w;
endmodule : code_check
`default_nettype wire

/* logic/msg_store.sv */
// calibration message text, kept apart from the non-volatile image
`timescale 1ns/10ps
`default_nettype none
`include "cal_lock_cfg.svh"
module msg_store (
   input wire logic clk_i,
   input wire logic wr_i,
   input wire logic [5:0] addr_i,
   input wire cal_lock_pkg::char_t data_i,
   output var cal_lock_pkg::char_t rd_data_o
);
   import cal_lock_pkg::*;
   // no reset: contents survive every reset
   char_t mem [0:`MSG_LEN-1];
   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= data_i;
      end
      rd_data_o <= (addr_i < `MSG_LEN) ? mem[addr_i] : 8'h00;
   end
endmodule : msg_store
`default_nettype wire

/* verification/nv_store_model.sv */
// non-volatile storage model facing the calibration lock
`timescale 1ns/10ps
`default_nettype none
module nv_store_model
   import cal_lock_pkg::*;
(
   input wire logic clk_i,
   input wire logic nv_write_i,
   input wire cal_lock_pkg::nv_image_t image_i,
   output logic blank_o,
   output cal_lock_pkg::nv_image_t image_o
);
   nv_image_t img_reg = '0;
   logic blank_reg = 1'b1;
   // unwritten cells read back as all ones
   assign blank_o = blank_reg;
   assign image_o = blank_reg ? ~img_reg : img_reg;
   // no reset: contents survive power loss of the device
   always @(posedge clk_i) begin
      if (nv_write_i === 1'b1) begin
         img_reg <= image_i;
         blank_reg <= 1'b0;
      end
   end
endmodule : nv_store_model
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the calibration lock
`timescale 1ns/10ps
`default_nettype none
module tb;
   import cal_lock_pkg::*;
   localparam int HOLD = 20;
   localparam int SHOW = 5;
   logic clk_i = 1'b0, rst_n_i = 1'b0, cal_key_i = 1'b0, fp_secure_i = 1'b0, jumper_i = 1'b0;
   logic cal_point_i = 1'b0, req_valid_i = 1'b0;
   logic [5:0][3:0] fp_digits_i = '0;
   req_t req_i = '0;
   logic req_ready_o, rsp_valid_o, nv_blank_i, nv_write_o, secured_o, cal_mode_o;
   rsp_t rsp_o;
   nv_image_t nv_image_i, nv_image_o;
   disp_t disp_o;
   char_t mc;
   int n_errors = 0;
   int checks = 0;
   logic sec_exp = 1'b1;
   rsp_t exp_q[$];
   op_t op_q[$];

   cal_lock #(.HOLD_CYC(HOLD), .SHOW_CYC(SHOW)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cal_key_i(cal_key_i),
      .fp_secure_i(fp_secure_i), .fp_digits_i(fp_digits_i), .jumper_i(jumper_i), .cal_point_i(cal_point_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_o(rsp_o), .nv_blank_i(nv_blank_i), .nv_image_i(nv_image_i), .nv_write_o(nv_write_o),
      .nv_image_o(nv_image_o), .secured_o(secured_o), .cal_mode_o(cal_mode_o), .disp_o(disp_o));

   nv_store_model nvm (.clk_i(clk_i), .nv_write_i(nv_write_o), .image_i(nv_image_o), .blank_o(nv_blank_i),
      .image_o(nv_image_i));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   function automatic code_t mk(input string s);
      code_t c;
      c = '0;
      c.len = 4'(s.len());
      for (int i = 0; i < s.len(); i++) begin
         c.ch[i] = s[i];
      end
      return c;
   endfunction : mk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : tick

   // one remote request; expectation queued for the monitor
   task automatic rq(input op_t op, input logic on, input string s, input logic [5:0] a, input char_t d,
                     input logic ok, input logic [14:0] cnt);
      int n;
      req_i = '{op: op, on: on, code: mk(s), msg_addr: a, msg_char: d};
      req_valid_i = 1'b1;
      if (op == set_security_state_cmd && ok) begin
         sec_exp = on;
      end
      exp_q.push_back('{ok: ok, secured: sec_exp, count: cnt, msg_char: d});
      op_q.push_back(op);
      n = 0;
      // ready judged settled, then the next edge takes the request
      while (req_ready_o !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      if (n >= 50) begin
         check(32'h1, 32'h0);
      end
      tick(1);
      req_valid_i = 1'b0;
      tick(1);
   endtask : rq

   task automatic wait_disp(input disp_t d, input int lim);
      int n;
      n = 0;
      while (disp_o !== d && n < lim) begin
         tick(1);
         n++;
      end
      check(disp_o, d);
   endtask : wait_disp

   task automatic power(input logic key);
      rst_n_i = 1'b0;
      cal_key_i = key;
      tick(10);
      rst_n_i = 1'b1;
      tick(2);
   endtask : power

   task automatic press();
      fp_secure_i = 1'b1;
      tick(1);
      fp_secure_i = 1'b0;
      tick(1);
   endtask : press

   task automatic cal_pt();
      cal_point_i = 1'b1;
      tick(1);
      cal_point_i = 1'b0;
      tick(1);
   endtask : cal_pt

   always @(negedge clk_i) begin : mon
      rsp_t e;
      op_t o;
      if (rsp_valid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            e = exp_q.pop_front();
            o = op_q.pop_front();
            check(rsp_o.ok, e.ok);
            check(rsp_o.secured, e.secured);
            if (o == read_calibration_counter_query) check(rsp_o.count, e.count);
            if (o == read_calibration_message_query) check(rsp_o.msg_char, e.msg_char);
         end
      end
   end

   initial begin
      #100000;
      check(32'h1, 32'h0);
      results();
   end

   initial begin
      void'($urandom(32'h2E9C));
      mc = 8'($urandom_range(8'h41, 8'h5A));
      // factory state, calibration mode through the panel
      power(1'b1);
      check(secured_o, 1'b1);
      wait_disp(DISP_SECURED, HOLD + 5);
      check(cal_mode_o, 1'b1);
      cal_key_i = 1'b0;
      wait_disp(DISP_CAL_MODE, SHOW + 3);
      cal_pt();
      rq(read_calibration_counter_query, 1'b0, "", 6'h00, 8'h00, 1'b1, 15'h0000);
      press();
      wait_disp(DISP_CODE, 4);
      fp_digits_i[0] = 4'($urandom_range(1, 9));
      press();
      wait_disp(DISP_INVALID, 3);
      check(secured_o, 1'b1);
      wait_disp(DISP_CODE, SHOW + 3);
      fp_digits_i = '0;
      press();
      wait_disp(DISP_UNSECURED, 3);
      wait_disp(DISP_CAL_MODE, SHOW + 3);
      check(secured_o, 1'b0);
      sec_exp = 1'b0;
      tick(1);
      check(nv_image_i.secured, 1'b0);
      cal_pt();
      rq(read_calibration_counter_query, 1'b0, "", 6'h00, 8'h00, 1'b1, 15'h0001);
      rq(store_calibration_message_cmd, 1'b0, "", 6'h03, mc, 1'b1, 15'h0000);
      rq(store_calibration_message_cmd, 1'b0, "", 6'h27, ~mc, 1'b1, 15'h0000);
      rq(store_calibration_message_cmd, 1'b0, "", 6'h28, mc, 1'b0, 15'h0000);
      rq(read_calibration_message_query, 1'b0, "", 6'h03, mc, 1'b1, 15'h0000);
      rq(read_calibration_message_query, 1'b0, "", 6'h27, ~mc, 1'b1, 15'h0000);
      rq(change_security_code_cmd, 1'b0, "9A", 6'h00, 8'h00, 1'b0, 15'h0000);
      rq(change_security_code_cmd, 1'b0, "ZQ123456", 6'h00, 8'h00, 1'b1, 15'h0000);
      rq(set_security_state_cmd, 1'b1, "ZQ000000", 6'h00, 8'h00, 1'b0, 15'h0000);
      rq(set_security_state_cmd, 1'b1, "ZQ12345", 6'h00, 8'h00, 1'b0, 15'h0000);
      rq(set_security_state_cmd, 1'b1, "7Q", 6'h00, 8'h00, 1'b0, 15'h0000);
      rq(set_security_state_cmd, 1'b1, "ZQ123456", 6'h00, 8'h00, 1'b1, 15'h0000);
      rq(change_security_code_cmd, 1'b0, "B2", 6'h00, 8'h00, 1'b0, 15'h0000);
      tick(2);
      check(secured_o, 1'b1);
      check(cal_mode_o, 1'b1);
      // power cycle without the key, jumper bypass
      power(1'b0);
      check(secured_o, 1'b1);
      rq(set_security_state_cmd, 1'b0, "ZQ999999", 6'h00, 8'h00, 1'b0, 15'h0000);
      jumper_i = 1'b1;
      rq(change_security_code_cmd, 1'b0, "Q7", 6'h00, 8'h00, 1'b1, 15'h0000);
      jumper_i = 1'b0;
      rq(set_security_state_cmd, 1'b0, "ZQ123456", 6'h00, 8'h00, 1'b0, 15'h0000);
      rq(set_security_state_cmd, 1'b0, "Q7", 6'h00, 8'h00, 1'b1, 15'h0000);
      rq(read_calibration_counter_query, 1'b0, "", 6'h00, 8'h00, 1'b1, 15'h0001);
      tick(HOLD + 5);
      check(cal_mode_o, 1'b0);
      check(secured_o, 1'b0);
      // counter at its top, unsecured calibration mode
      nvm.img_reg.count = 15'h7FFF;
      power(1'b1);
      check(secured_o, 1'b0);
      wait_disp(DISP_UNSECURED, HOLD + 5);
      cal_key_i = 1'b0;
      wait_disp(DISP_CAL_MODE, SHOW + 3);
      cal_pt();
      rq(read_calibration_counter_query, 1'b0, "", 6'h00, 8'h00, 1'b1, 15'h0000);
      // panel entry while unsecured stores a new code and secures
      fp_digits_i = 24'h654321;
      press();
      wait_disp(DISP_CODE, 4);
      press();
      wait_disp(DISP_SECURED, 3);
      check(secured_o, 1'b1);
      sec_exp = 1'b1;
      rq(set_security_state_cmd, 1'b0, "Q7", 6'h00, 8'h00, 1'b0, 15'h0000);
      rq(set_security_state_cmd, 1'b0, "Q7123456", 6'h00, 8'h00, 1'b1, 15'h0000);
      rq(set_security_state_cmd, 1'b1, "Q7123456", 6'h00, 8'h00, 1'b1, 15'h0000);
      tick(3);
      check(exp_q.size(), 32'h0);
      results();
   end
endmodule : tb
`default_nettype wire
